// >>> rtl/pde_path.sv
// panel output path: expansion, dither, pin mapping, emi skew
// assumes stream, row/frame pulses and index port share clk
`timescale 1ns/10ps
// What this block does
// - active pins 9/12/18/24 single or 24/36 pair
// - pair mode: first pixel A, second B
// - index 58h bit 3 switches emi skew
// - emi on: six-pin groups get skew codes
// - expansion works for both panel kinds
// - horizontal pieces of eight source pixels
// - ratio select: ten or twelve per piece
// - ten-dot repeats p3 and p7
// - twelve-dot repeats p1 p3 p5 p7
// - nine-dot text: second p7 is background
// - ten-bit software loaded line step
// - each line adds step into accumulator
// - accumulator clears per row or frame
// - passive dither, bit 5 picks 16/32 grays
// - active dither, bits 7:6 pick mode
module pde_path #(
  parameter int MAX_W = 1024
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // index/data register port
  input  wire pde_pkg::pde_io_type io_req,
  output logic [7:0]               io_rdata_q,
  // source stream
  input  wire pde_pkg::pde_src_type src,
  input  wire logic                row_start,
  input  wire logic                frame_end,
  output logic                     src_ready_q,
  // panel side
  output logic [35:0]              pnl_data_q,
  output logic                     pnl_de_q,
  output logic                     pnl_line_q,
  output logic [11:0]              emi_dly_q
);
  import pde_pkg::*;
  localparam int AW = $clog2(MAX_W);
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  logic [7:0] idx_q, exp_q, pnl_q, dith_q, emi_q;
  logic [STEP_W-1:0] step_q;
  logic [ACC_W-1:0]  acc_q;
  wire data_wr = io_req.wr & io_req.sel;
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_q  <= REG_RST;
      exp_q  <= REG_RST;
      pnl_q  <= REG_RST;
      dith_q <= REG_RST;
      emi_q  <= REG_RST;
      step_q <= '0;
    end else begin
      if (io_req.wr & ~io_req.sel)
        idx_q <= io_req.wdata;
      if (data_wr) begin
        case (idx_q)
          IDX_EXP:     exp_q  <= io_req.wdata;
          IDX_PNL:     pnl_q  <= io_req.wdata;
          IDX_DITH:    dith_q <= io_req.wdata;
          IDX_EMI:     emi_q  <= io_req.wdata;
          IDX_STEP_LO: step_q[7:0] <= io_req.wdata;
          IDX_STEP_HI: step_q[9:8] <= io_req.wdata[1:0];
          default: ;
        endcase
      end
    end
  end
  wire [7:0] rd_mux =
    ~io_req.sel           ? idx_q :
    idx_q == IDX_EXP      ? exp_q :
    idx_q == IDX_PNL      ? pnl_q :
    idx_q == IDX_DITH     ? dith_q :
    idx_q == IDX_EMI      ? emi_q :
    idx_q == IDX_STEP_LO  ? step_q[7:0] :
    idx_q == IDX_STEP_HI  ? {6'h00, step_q[9:8]} :
    idx_q == IDX_ACC_LO   ? acc_q[7:0] :
    idx_q == IDX_ACC_HI   ? {5'h00, acc_q[10:8]} : 8'h00;
  // ---------------------------------------------
  // expansion sequencer
  // ---------------------------------------------
  pde_state_type state_q, state_d;
  pde_pix_type   buf_mem [MAX_W];
  pde_pix_type   e_pix_q, e_pix_d, dup_pix_q, dup_pix_d;
  logic e_valid_q, e_valid_d, e_last_q, e_last_d;
  logic dup_last_q, dup_last_d, end_line;
  logic [2:0] pos_q;
  logic [AW-1:0] wr_q, len_q, rd_q;
  // one sequencer serves either panel kind
  wire accept = src.valid & src_ready_q;
  // piece position picks repeats
  wire dup_hit = exp_q[EXP_HEN] & (exp_q[EXP_R12] ? pos_q[0]
                 : pos_q[1:0] == 2'b11);
  wire bg_sel = exp_q[EXP_NINE] & src.text & (pos_q == 3'h7);
  wire pde_pix_type dup_val = bg_sel ? src.bg : src.pix;
  wire [ACC_W-1:0] next_accumulator =
    {1'b0, acc_q[9:0]} + {1'b0, step_q};
  wire vdup = exp_q[EXP_VEN] & next_accumulator[10];
  wire rst_ev = exp_q[EXP_TEXT] ? row_start : frame_end;
  always_comb begin
    state_d    = state_q;
    e_valid_d  = 1'b0;
    e_last_d   = 1'b0;
    e_pix_d    = src.pix;
    dup_pix_d  = dup_pix_q;
    dup_last_d = dup_last_q;
    end_line   = 1'b0;
    unique case (state_q)
      ST_PASS: begin
        if (accept) begin
          e_valid_d = 1'b1;
          e_last_d  = src.last & ~dup_hit;
          end_line  = src.last & ~dup_hit;
          if (dup_hit) begin
            state_d    = ST_DUP;
            dup_pix_d  = dup_val;
            dup_last_d = src.last;
          end
        end
      end
      ST_DUP: begin
        e_valid_d = 1'b1;
        e_pix_d   = dup_pix_q;
        e_last_d  = dup_last_q;
        end_line  = dup_last_q;
        state_d   = ST_PASS;
      end
      ST_REPLAY: begin
        e_valid_d = 1'b1;
        e_pix_d   = buf_mem[rd_q];
        e_last_d  = rd_q == len_q;
        if (rd_q == len_q)
          state_d = ST_PASS;
      end
    endcase
    if (end_line && vdup)
      state_d = ST_REPLAY;
  end
  // line buffer holds the expanded line for a repeat
  always_ff @(posedge clk) begin
    if (e_valid_d && state_q != ST_REPLAY)
      buf_mem[wr_q] <= e_pix_d;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q     <= ST_PASS;
      src_ready_q <= 1'b0;
      e_valid_q   <= 1'b0;
      e_last_q    <= 1'b0;
      e_pix_q     <= '0;
      dup_pix_q   <= '0;
      dup_last_q  <= 1'b0;
      pos_q       <= 3'h0;
      wr_q        <= '0;
      len_q       <= '0;
      rd_q        <= '0;
      acc_q       <= '0;
    end else begin
      state_q     <= state_d;
      src_ready_q <= state_d == ST_PASS;
      e_valid_q   <= e_valid_d;
      e_last_q    <= e_last_d;
      e_pix_q     <= e_pix_d;
      dup_pix_q   <= dup_pix_d;
      dup_last_q  <= dup_last_d;
      if (accept)
        pos_q <= src.last ? 3'h0 : pos_q + 3'h1;
      // overlong lines clip at the buffer end
      if (e_valid_d && state_q != ST_REPLAY)
        wr_q <= end_line ? '0 : (wr_q == AW'(MAX_W - 1) ? wr_q
                : wr_q + AW'(1));
      if (end_line)
        len_q <= wr_q;
      rd_q <= state_q == ST_REPLAY ? rd_q + AW'(1) : '0;
      if (rst_ev)
        acc_q <= '0;
      else if (end_line)
        acc_q <= {1'b0, next_accumulator[9:0]};
    end
  end
  // ---------------------------------------------
  // dither and pin mapping
  // ---------------------------------------------
  logic [9:0] x_q, y_q;
  logic [2:0] f_q;
  logic half_q;
  logic [23:0] a_q, qv;
  wire [35:0] pr;
  wire pair = pnl_q[PNL_PAIR];
  wire pasv = pnl_q[PNL_PASV];
  wire [1:0] tsel = dith_q[7:DITH_TLO];
  // reserved code 11 falls back to no dither
  wire dith_on = pasv | tsel == ACT_G4 | tsel == ACT_G8;
  wire [3:0] nb = pnl_q[1:0] == 2'b00 ? 4'd3 : pnl_q[1:0] == 2'b01
                  ? 4'd4 : pnl_q[1:0] == 2'b10 ? 4'd6 : 4'd8;
  wire [3:0] kb = pasv ? (dith_q[DITH_G32] ? 4'd5 : 4'd4)
                  : (tsel == ACT_G8 ? 4'd3 : 4'd2);
  wire [2:0] pat3 = {f_q[0] ^ y_q[1], y_q[0], x_q[0] ^ f_q[1]};
  wire [4:0] pat5 = {f_q, y_q[0], x_q[0]};
  wire [7:0] thr8 = pasv ? {pat5, 3'h0} : {pat3, 5'h00};
  wire [7:0] kmask = ~(8'hFF >> kb);
  wire [7:0] vmax = ~(8'hFF << nb);
  wire [23:0] pa = half_q ? a_q : qv;
  wire [23:0] pb = half_q ? qv : 24'h000000;
  genvar c;
  for (c = 0; c < 3; c++) begin : g_ch
    wire [15:0] sh = {8'h00, e_pix_q[8*c+7 -: 8]} << nb;
    wire inc = dith_on & ((sh[7:0] & kmask) > thr8)
               & (sh[15:8] != vmax);
    assign qv[8*c+7 -: 8] = sh[15:8] + {7'h00, inc};
    // pair layout: low nibble A, next nibble B, top bits above 24
    assign pr[8*c+3 -: 4] = pa[8*c+3 -: 4];
    assign pr[8*c+7 -: 4] = pb[8*c+3 -: 4];
    assign pr[24+4*c+1 -: 2] = pa[8*c+5 -: 2];
    assign pr[24+4*c+3 -: 2] = pb[8*c+5 -: 2];
  end
  wire emit = e_valid_q & (~pair | half_q | e_last_q);
  always_ff @(posedge clk) begin
    if (reset) begin
      pnl_data_q <= '0;
      pnl_de_q   <= 1'b0;
      pnl_line_q <= 1'b0;
      emi_dly_q  <= '0;
      io_rdata_q <= 8'h00;
      half_q     <= 1'b0;
      a_q        <= '0;
      x_q        <= '0;
      y_q        <= '0;
      f_q        <= '0;
    end else begin
      io_rdata_q <= rd_mux;
      pnl_de_q   <= emit;
      pnl_line_q <= emit & e_last_q;
      if (emit)
        pnl_data_q <= pair ? pr : {12'h000, qv};
      // skew codes drive the pad delay taps
      emi_dly_q <= emi_q[EMI_EN] ? EMI_CODES : 12'h000;
      if (e_valid_q) begin
        half_q <= pair & ~half_q & ~e_last_q;
        a_q    <= qv;
        x_q    <= e_last_q ? 10'h000 : x_q + 10'h001;
        if (e_last_q)
          y_q <= y_q + 10'h001;
      end
      if (frame_end) begin
        y_q <= 10'h000;
        f_q <= f_q + 3'h1;
      end
    end
  end
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  property p_emi_on;
    @(posedge clk) disable iff (reset)
    emi_q[EMI_EN] |=> emi_dly_q == EMI_CODES;
  endproperty
  a_emi_on: assert property (p_emi_on) else $error("emi codes");
  property p_emi_off;
    @(posedge clk) disable iff (reset)
    data_wr && idx_q == IDX_EMI && !io_req.wdata[3]
    |=> ##1 emi_dly_q == 12'h000;
  endproperty
  a_emi_off: assert property (p_emi_off) else $error("emi off");
  property p_ten;
    @(posedge clk) disable iff (reset)
    accept && exp_q[EXP_HEN] && !exp_q[EXP_R12] && pos_q == 3'h3
    |=> !src_ready_q ##1 e_pix_q == $past(src.pix, 2);
  endproperty
  a_ten: assert property (p_ten) else $error("p3 repeat");
  property p_twelve;
    @(posedge clk) disable iff (reset)
    accept && exp_q[EXP_HEN] && exp_q[EXP_R12] && pos_q[0]
    |=> state_q == ST_DUP;
  endproperty
  a_twelve: assert property (p_twelve) else $error("odd repeat");
  property p_plain;
    @(posedge clk) disable iff (reset)
    accept && !src.last && (!exp_q[EXP_HEN]
    || exp_q[EXP_R12] && !pos_q[0]) |=> src_ready_q;
  endproperty
  a_plain: assert property (p_plain) else $error("stray repeat");
  property p_bg;
    @(posedge clk) disable iff (reset)
    accept && dup_hit && bg_sel |=> ##1 e_pix_q == $past(src.bg, 2);
  endproperty
  a_bg: assert property (p_bg) else $error("bg dot");
  property p_acc;
    @(posedge clk) disable iff (reset)
    end_line && !rst_ev |=> acc_q[10] == 1'b0
    && acc_q[9:0] == 10'($past(acc_q[9:0]) + $past(step_q));
  endproperty
  a_acc: assert property (p_acc) else $error("acc step");
  property p_carry;
    @(posedge clk) disable iff (reset)
    end_line && vdup |=> state_q == ST_REPLAY && !src_ready_q;
  endproperty
  a_carry: assert property (p_carry) else $error("no line dup");
  property p_clear;
    @(posedge clk) disable iff (reset)
    rst_ev |=> acc_q == 11'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("acc clear");
  c_replay: cover property (@(posedge clk) state_q == ST_REPLAY
    ##1 state_q == ST_PASS);
  c_dup12: cover property (@(posedge clk) accept && exp_q[EXP_R12]
    && dup_hit);
  c_pair: cover property (@(posedge clk) emit && pair && half_q);
  c_emi: cover property (@(posedge clk) emi_dly_q == EMI_CODES);
endmodule

// >>> shared/pde_pkg.sv
// panel expand/dither path: indices, fields, types
// assumes one pixel clock for registers and stream
package pde_pkg;
  // ---------------------------------------------
  // register indices behind the data port
  // ---------------------------------------------
  localparam logic [7:0] IDX_EXP     = 8'h30;
  localparam logic [7:0] IDX_PNL     = 8'h31;
  localparam logic [7:0] IDX_DITH    = 8'h32;
  localparam logic [7:0] IDX_STEP_LO = 8'h34;
  localparam logic [7:0] IDX_STEP_HI = 8'h35;
  localparam logic [7:0] IDX_ACC_LO  = 8'h36;
  localparam logic [7:0] IDX_ACC_HI  = 8'h37;
  localparam logic [7:0] IDX_EMI     = 8'h58;
  localparam logic [7:0] REG_RST     = 8'h00;
  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int EXP_HEN  = 0;
  localparam int EXP_R12  = 1;
  localparam int EXP_NINE = 2;
  localparam int EXP_VEN  = 3;
  localparam int EXP_TEXT = 4;
  localparam int PNL_PAIR = 2;
  localparam int PNL_PASV = 3;
  localparam int DITH_G32 = 5;
  localparam int DITH_TLO = 6;
  localparam int EMI_EN   = 3;
  // ---------------------------------------------
  // sizes and codes
  // ---------------------------------------------
  localparam int STEP_W = 10;
  localparam int ACC_W  = 11;
  localparam int PIN_W  = 36;
  localparam logic [1:0] ACT_OFF = 2'b00;
  localparam logic [1:0] ACT_G4  = 2'b01;
  localparam logic [1:0] ACT_G8  = 2'b10;
  // two bits per six-pin group, group g gets code g mod 4
  localparam logic [11:0] EMI_CODES = 12'h4E4;
  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pde_pix_type;
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pde_io_type;
  typedef struct packed {
    logic        valid;
    logic        last;
    logic        text;
    pde_pix_type pix;
    pde_pix_type bg;
  } pde_src_type;
  typedef enum {ST_PASS, ST_DUP, ST_REPLAY} pde_state_type;
endpackage

// >>> verif/pde_panel_model.sv
// panel model: a sink that records every enabled word and line end
// assumes the block drives its pins from registers on rising clk
`timescale 1ns/10ps
module pde_panel_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // panel pins
  input wire logic [35:0] data,
  input wire logic        de,
  input wire logic        line
);
  logic [35:0] words[$];
  int          lines = 0;
  // -----------------------------------------
  // capture
  // -----------------------------------------
  // a panel latches one word per enable and ignores pins otherwise
  always @(posedge clk) begin
    if (!reset) begin
      if (de) words.push_back(data);
      if (line) lines <= lines + 1;
    end
  end
endmodule

// >>> verif/tb.sv
// testbench: register port, emi codes, dither modes, expansion
// assumes one clock; pixels and register writes change at negedge
`timescale 1ns/10ps
module tb;
  import pde_pkg::*;
  logic        clk = 0;
  logic        reset = 1;
  pde_io_type  io_req = '0;
  pde_src_type src = '0;
  logic        frame_end = 0;
  logic        row_start = 0;
  logic [7:0]  io_rdata_q;
  logic        src_ready_q;
  logic [35:0] pnl_data_q;
  logic        pnl_de_q;
  logic        pnl_line_q;
  logic [11:0] emi_dly_q;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  // short line buffer keeps the replay quick
  pde_path #(.MAX_W(16)) pde_path_i (
    .clk(clk), .reset(reset), .io_req(io_req), .io_rdata_q(io_rdata_q),
    .src(src), .row_start(row_start), .frame_end(frame_end),
    .src_ready_q(src_ready_q), .pnl_data_q(pnl_data_q),
    .pnl_de_q(pnl_de_q), .pnl_line_q(pnl_line_q), .emi_dly_q(emi_dly_q));
  pde_panel_model pde_panel_model_i (
    .clk(clk), .reset(reset), .data(pnl_data_q), .de(pnl_de_q),
    .line(pnl_line_q));

  // -----------------------------------------
  // helpers
  // -----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [35:0] exp,
                     input logic [35:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic io_wr(input logic sel, input logic [7:0] d);
    @(negedge clk);
    io_req = '{sel: sel, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    io_req.wr = 1'b0;
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io_wr(1'b0, idx);
    io_wr(1'b1, d);
  endtask

  // read data lags the addressed place by one cycle
  task automatic rreg(input logic [7:0] idx, output logic [7:0] d);
    @(negedge clk);
    io_req = '{sel: 1'b0, wr: 1'b1, rd: 1'b0, wdata: idx};
    @(negedge clk);
    io_req = '{sel: 1'b1, wr: 1'b0, rd: 1'b1, wdata: idx};
    @(negedge clk);
    d = io_rdata_q;
  endtask

  // index 8 stands for the background colour
  function automatic logic [35:0] exp_word(input int i);
    if (i == 8) return {12'h000, 24'h5A5A5A};
    return {12'h000, 8'h01 + 8'(i), 8'h40 + 8'(i), 8'h80 + 8'(i)};
  endfunction

  // pair pins at six bits per channel: A low nibble, B next, tops above 24
  function automatic logic [35:0] exp_pair(input logic [23:0] a,
                                           input logic [23:0] b);
    logic [35:0] w;
    logic [5:0]  qa;
    logic [5:0]  qb;
    w = '0;
    for (int c = 0; c < 3; c++) begin
      qa = a[8*c+7 -: 6];
      qb = b[8*c+7 -: 6];
      w[8*c +: 4] = qa[3:0];
      w[8*c+4 +: 4] = qb[3:0];
      w[24+4*c +: 2] = qa[5:4];
      w[26+4*c +: 2] = qb[5:4];
    end
    return w;
  endfunction

  task automatic send_line(input logic text);
    logic [35:0] w;
    for (int i = 0; i < 8; i++) begin
      w = exp_word(i);
      src = '{valid: 1'b1, last: i == 7, text: text, pix: w[23:0],
              bg: 24'h5A5A5A};
      while (!src_ready_q) @(negedge clk);
      @(negedge clk);
    end
    src = '0;
  endtask

  task automatic wait_lines(input int n);
    for (int k = 0; k < 300 && pde_panel_model_i.lines < n; k++)
      @(negedge clk);
    repeat (4) @(negedge clk);
  endtask

  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic t_regs();
    logic [7:0] v;
    rreg(IDX_EMI, v);
    chk("emi reset", 36'(REG_RST), 36'(v));
    chk("emi codes reset", 36'h0, 36'(emi_dly_q));
    rreg(8'h40, v);
    chk("unmapped", 36'h0, 36'(v));
    wreg(IDX_ACC_LO, 8'hFF);
    rreg(IDX_ACC_LO, v);
    chk("acc read only", 36'h0, 36'(v));
    $display("test regs done");
  endtask

  task automatic t_emi();
    logic [7:0] v;
    wreg(IDX_EMI, 8'h08);
    repeat (2) @(negedge clk);
    chk("emi codes on", 36'(EMI_CODES), 36'(emi_dly_q));
    rreg(IDX_EMI, v);
    chk("emi reg", 36'h08, 36'(v));
    wreg(IDX_EMI, 8'h00);
    repeat (2) @(negedge clk);
    chk("emi codes off", 36'h0, 36'(emi_dly_q));
    $display("test emi done");
  endtask

  task automatic t_dith();
    logic [7:0] v;
    logic [7:0] m[4] = '{8'h40, 8'h80, 8'h20, 8'h00};
    foreach (m[k]) begin
      wreg(IDX_DITH, m[k]);
      rreg(IDX_DITH, v);
      chk("dither ctrl", 36'(m[k]), 36'(v));
    end
    $display("test dither done");
  endtask

  task automatic t_expand(input string nm, input logic [7:0] ctrl,
                          input logic text, input logic [47:0] order,
                          input int n);
    int l0;
    wreg(IDX_EXP, ctrl);
    pde_panel_model_i.words.delete();
    l0 = pde_panel_model_i.lines;
    send_line(text);
    wait_lines(l0 + 1);
    chk(nm, 36'(n), 36'(pde_panel_model_i.words.size()));
    for (int j = 0; j < n; j++)
      chk(nm, exp_word(int'(order[47-4*j -: 4])),
          pde_panel_model_i.words[j]);
    $display("test %s done", nm);
  endtask

  task automatic t_vert();
    logic [7:0] v;
    int l0;
    wreg(IDX_EXP, 8'h08);
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
    wreg(IDX_STEP_LO, 8'h00);
    wreg(IDX_STEP_HI, 8'h03); // step 768: seven lines out per four
    rreg(IDX_STEP_HI, v);
    chk("step hi", 36'h3, 36'(v));
    pde_panel_model_i.words.delete();
    l0 = pde_panel_model_i.lines;
    send_line(1'b0);
    wait_lines(l0 + 1);
    rreg(IDX_ACC_HI, v);
    chk("acc one line", 36'h3, 36'(v));
    send_line(1'b0);
    wait_lines(l0 + 3);
    chk("dup words", 36'd24, 36'(pde_panel_model_i.words.size()));
    rreg(IDX_ACC_HI, v);
    chk("acc carry cleared", 36'h2, 36'(v));
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
    rreg(IDX_ACC_HI, v);
    chk("acc frame clear", 36'h0, 36'(v));
    wreg(IDX_EXP, 8'h18);
    send_line(1'b1);
    wait_lines(l0 + 4);
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
    rreg(IDX_ACC_HI, v);
    chk("text ignores frame", 36'h3, 36'(v));
    row_start = 1'b1;
    @(negedge clk);
    row_start = 1'b0;
    rreg(IDX_ACC_HI, v);
    chk("acc row clear", 36'h0, 36'(v));
    $display("test vertical done");
  endtask

  task automatic t_pair();
    logic [35:0] a;
    logic [35:0] b;
    int l0;
    wreg(IDX_PNL, 8'h06);
    wreg(IDX_EXP, 8'h00);
    pde_panel_model_i.words.delete();
    l0 = pde_panel_model_i.lines;
    send_line(1'b0);
    wait_lines(l0 + 1);
    chk("pair count", 36'd4, 36'(pde_panel_model_i.words.size()));
    for (int j = 0; j < 4; j++) begin
      a = exp_word(2 * j);
      b = exp_word(2 * j + 1);
      chk("pair word", exp_pair(a[23:0], b[23:0]),
          pde_panel_model_i.words[j]);
    end
    $display("test pair done");
  endtask

  // three bits per channel: dither may add one step, never more
  task automatic t_dout(input string nm, input logic [7:0] ctrl,
                        input logic on);
    logic [35:0] w;
    logic [35:0] g;
    logic [7:0]  t;
    logic        ok;
    int l0;
    wreg(IDX_DITH, ctrl);
    pde_panel_model_i.words.delete();
    l0 = pde_panel_model_i.lines;
    send_line(1'b0);
    wait_lines(l0 + 1);
    chk(nm, 36'd8, 36'(pde_panel_model_i.words.size()));
    for (int j = 0; j < 8; j++) begin
      w = exp_word(j);
      g = pde_panel_model_i.words[j];
      ok = g[35:24] == 12'h000;
      for (int c = 0; c < 3; c++) begin
        t = {5'h00, w[8*c+7 -: 3]};
        ok = ok & ((g[8*c +: 8] == t) | (on & (g[8*c +: 8] == t + 8'h01)));
      end
      chk(nm, 36'h1, 36'(ok));
    end
    $display("test %s done", nm);
  endtask

  // -----------------------------------------
  // sequence
  // -----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    t_regs();
    t_emi();
    t_dith();
    wreg(IDX_PNL, 8'h03);
    t_expand("ten dot", 8'h01, 1'b0, 48'h012334567700, 10);
    t_expand("twelve dot", 8'h03, 1'b0, 48'h011233455677, 12);
    t_expand("nine text", 8'h05, 1'b1, 48'h012334567800, 10);
    t_expand("nine gfx", 8'h05, 1'b0, 48'h012334567700, 10);
    wreg(IDX_PNL, 8'h0B);
    t_expand("passive ten", 8'h01, 1'b0, 48'h012334567700, 10);
    t_vert();
    t_pair();
    wreg(IDX_PNL, 8'h00);
    t_dout("dither off", 8'h00, 1'b0);
    t_dout("dither g4", 8'h40, 1'b1);
    t_dout("dither g8", 8'h80, 1'b1);
    t_dout("dither code 11", 8'hC0, 1'b0);
    wreg(IDX_PNL, 8'h08);
    t_dout("passive 32", 8'h20, 1'b1);
    t_dout("passive 16", 8'h00, 1'b1);
    stop_test();
  end
endmodule
